/* hdl/tid_params.svh */
`ifndef TID_PARAMS_SVH
`define TID_PARAMS_SVH

// register indexes; byte address on the bus is four times the index
`define TID_IDX_VECTOR      8'hF9
`define TID_IDX_RX_ADDR     8'hFA
`define TID_IDX_RX_COUNT    8'hFB
`define TID_IDX_TX_ADDR     8'hFC
`define TID_IDX_TX_COUNT    8'hFD
`define TID_IDX_CLK_EXT     8'hFE
`define TID_IDX_MASK        8'hFF

// bus address width in bits
`define TID_ADDR_W          10

// vector register fields
`define TID_VEC_BASE_HI     7
`define TID_VEC_BASE_LO     3
`define TID_VEC_CODE_HI     2
`define TID_VEC_CODE_LO     1

// pointer registers: location in bits 7:1, selector in bit 0
`define TID_PTR_HI          7
`define TID_PTR_LO          1
`define TID_SEL_BIT         0

// clock extension register fields
`define TID_DIV_HI_HI       1
`define TID_DIV_HI_LO       0

// mask register fields
`define TID_MSK_RX_DMA      7
`define TID_MSK_TX_DMA      6
`define TID_MSK_RX_DONE     5
`define TID_MSK_TX_DONE     4
`define TID_MSK_ERR         2
`define TID_MSK_RX          1
`define TID_MSK_TX          0

// reset values
`define TID_RST_BYTE        8'h00
`define TID_RST_DIV_HI      2'h0
`define TID_RST_CODE        2'h0

// divider: phases per bus clock period
`define TID_DIV_PHASES_STD  2'h2
`define TID_DIV_PHASES_FAST 2'h3
`define TID_DIV_OFFSET      10'h002

`endif

/* hdl/tid_pkg.sv */
package tid_pkg;

    // encoded interrupt source reported in the vector
    typedef enum logic [1:0] {
        TID_SRC_NONE = 2'b00,
        TID_SRC_ERR  = 2'b01,
        TID_SRC_RX   = 2'b10,
        TID_SRC_TX   = 2'b11
    } tid_src_t;

    // bus slave answer sequence
    typedef enum logic {
        TID_BUS_IDLE   = 1'b0,
        TID_BUS_ANSWER = 1'b1
    } tid_bus_state_t;

endpackage : tid_pkg

/* hdl/tid_div.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tid_params.svh"

// bus clock generator: period = (2 or 3) x (divider + 2) core cycles
module tid_div (
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       run,
    input  wire logic       fast,
    input  wire logic [8:0] divider,
    output logic            bus_clk_level,
    output logic            bus_clk_tick
);

    logic [9:0] cnt_ff;       // cycles inside one phase
    logic [9:0] nxt_cnt;
    logic [1:0] phase_ff;     // phase within one bus period
    logic [1:0] nxt_phase;
    logic       level_ff;
    logic       nxt_level;
    logic       tick_ff;
    logic       nxt_tick;
    logic [9:0] phase_len;    // divider plus two
    logic [1:0] last_phase;

    assign phase_len  = {1'b0, divider} + `TID_DIV_OFFSET;
    assign last_phase = fast ? (`TID_DIV_PHASES_FAST - 2'h1)
                             : (`TID_DIV_PHASES_STD - 2'h1);

    // count phases; while running, the clock is high only in the last phase
    always_comb begin
        nxt_cnt   = cnt_ff;
        nxt_phase = phase_ff;
        nxt_tick  = 1'b0;
        if (!run) begin
            // idle: hold the line high, restart cleanly
            nxt_cnt   = 10'h000;
            nxt_phase = 2'h0;
        end else if (cnt_ff >= phase_len - 10'h001) begin
            nxt_cnt = 10'h000;
            if (phase_ff >= last_phase) begin
                nxt_phase = 2'h0;
                nxt_tick  = 1'b1;
            end else begin
                nxt_phase = phase_ff + 2'h1;
            end
        end else begin
            nxt_cnt = cnt_ff + 10'h001;
        end
        nxt_level = !run || (nxt_phase == last_phase);
    end

    // registers only
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff   <= 10'h000;
            phase_ff <= 2'h0;
            level_ff <= 1'b1;
            tick_ff  <= 1'b0;
        end else begin
            cnt_ff   <= nxt_cnt;
            phase_ff <= nxt_phase;
            level_ff <= nxt_level;
            tick_ff  <= nxt_tick;
        end
    end

    assign bus_clk_level = level_ff;
    assign bus_clk_tick  = tick_ff;

endmodule : tid_div

`default_nettype wire

/* hdl/tid_top.sv */
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tid_params.svh"

module tid_top (
    input  wire logic                   ref_clk,
    input  wire logic                   rst_b,
    // avalon-mm slave
    input  wire logic [`TID_ADDR_W-1:0] avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic [31:0]                 avs_readdata,
    output logic                        avs_waitrequest,
    // state from the rest of the interface
    input  wire logic                   interface_on,
    input  wire logic                   fast_speed_select,
    input  wire logic [6:0]             divider_low_bits,
    input  wire logic                   dma_hold_select,
    input  wire logic                   error_pending,
    input  wire logic                   rx_data_pending,
    input  wire logic                   tx_ready_pending,
    // dma controller side
    input  wire logic                   rx_dma_last,
    input  wire logic                   tx_dma_last,
    output logic                        rx_dma_req,
    output logic                        tx_dma_req,
    output logic [6:0]                  rx_dma_addr_ptr,
    output logic                        rx_dma_ext_select,
    output logic [6:0]                  rx_dma_count_ptr,
    output logic                        rx_dma_target_select,
    output logic [6:0]                  tx_dma_addr_ptr,
    output logic                        tx_dma_ext_select,
    output logic [6:0]                  tx_dma_count_ptr,
    output logic                        tx_dma_target_select,
    // interrupt controller side
    input  wire logic                   irq_ack,
    output logic                        irq_req,
    output logic [7:0]                  irq_vector_out,
    // bus clock
    output logic [8:0]                  bus_divider,
    output logic                        bus_clk_level,
    output logic                        bus_clk_tick
);

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    tid_pkg::tid_bus_state_t bus_state_ff;   // answer cycle marker
    tid_pkg::tid_bus_state_t nxt_bus_state;
    logic [31:0] rdata_ff;                   // registered read data
    logic [31:0] nxt_rdata;
    logic [7:0]  idx;                        // register index of access
    logic        aligned;                    // low address bits are zero
    logic        wr_take;                    // write takes effect now
    logic        wr_lane0;                   // low byte lane enabled
    logic [7:0]  wdat;                       // low byte of write data

    assign idx      = avs_address[`TID_ADDR_W-1:2];
    assign aligned  = (avs_address[1:0] == 2'h0);
    assign wdat     = avs_writedata[7:0];
    assign wr_lane0 = avs_byteenable[0];
    // one wait state: the request is taken on the answer edge only
    assign wr_take  = avs_write && (bus_state_ff == tid_pkg::TID_BUS_ANSWER)
                      && aligned && wr_lane0;

    ////////////////////////////////////////////////////////////////////////
    // register storage

    logic [4:0] vec_base_ff;           // vector base, bits 7:3
    logic [4:0] nxt_vec_base;
    logic [7:0] rx_addr_ff;            // rx address pointer register
    logic [7:0] nxt_rx_addr;
    logic [7:0] rx_count_ff;           // rx counter pointer register
    logic [7:0] nxt_rx_count;
    logic [7:0] tx_addr_ff;            // tx address pointer register
    logic [7:0] nxt_tx_addr;
    logic [7:0] tx_count_ff;           // tx counter pointer register
    logic [7:0] nxt_tx_count;
    logic [1:0] div_hi_ff;             // divider bits 8:7
    logic [1:0] nxt_div_hi;
    logic       rx_dma_enable_ff;
    logic       nxt_rx_dma_enable;
    logic       tx_dma_enable_ff;
    logic       nxt_tx_dma_enable;
    logic       rx_block_done_flag_ff;
    logic       nxt_rx_block_done_flag;
    logic       tx_block_done_flag_ff;
    logic       nxt_tx_block_done_flag;
    logic       error_irq_mask_ff;
    logic       nxt_error_irq_mask;
    logic       rx_irq_mask_ff;
    logic       nxt_rx_irq_mask;
    logic       tx_irq_mask_ff;
    logic       nxt_tx_irq_mask;
    tid_pkg::tid_src_t code_ff;        // source code latched for the vector
    tid_pkg::tid_src_t nxt_code;
    tid_pkg::tid_src_t live_code;      // current winning source

    ////////////////////////////////////////////////////////////////////////
    // request arbitration

    logic err_irq_live;    // error interrupt unmasked and pending
    logic rx_irq_live;     // data received or rx block end unmasked
    logic tx_irq_live;     // ready to transmit or tx block end unmasked
    logic suspended;       // dma held off by a pending error
    logic dma_busy;        // any dma request outstanding

    // suspended mode when the hold select is low
    assign suspended = !dma_hold_select && error_pending;

    // dma requests ignore the interrupt masks on purpose
    assign rx_dma_req = rx_dma_enable_ff && rx_data_pending
                        && !suspended;
    assign tx_dma_req = tx_dma_enable_ff && tx_ready_pending
                        && !suspended;
    assign dma_busy   = rx_dma_req || tx_dma_req;

    // in not-suspended mode a live dma request outranks the error
    assign err_irq_live = error_irq_mask_ff && error_pending
                          && (!dma_hold_select || !dma_busy);
    // data events served by dma raise no interrupt of their own
    assign rx_irq_live  = rx_irq_mask_ff
                          && (rx_block_done_flag_ff
                          || (rx_data_pending && !rx_dma_enable_ff));
    assign tx_irq_live  = tx_irq_mask_ff
                          && (tx_block_done_flag_ff
                          || (tx_ready_pending && !tx_dma_enable_ff));

    // fixed priority: error, then receive, then transmit
    always_comb begin
        if (err_irq_live) begin
            live_code = tid_pkg::TID_SRC_ERR;
        end else if (rx_irq_live) begin
            live_code = tid_pkg::TID_SRC_RX;
        end else if (tx_irq_live) begin
            live_code = tid_pkg::TID_SRC_TX;
        end else begin
            live_code = tid_pkg::TID_SRC_NONE;
        end
    end

    assign irq_req = (live_code != tid_pkg::TID_SRC_NONE);

    ////////////////////////////////////////////////////////////////////////
    // next register values

    // software writes, hardware sets and clears; hardware beats software
    always_comb begin
        nxt_vec_base           = vec_base_ff;
        nxt_rx_addr            = rx_addr_ff;
        nxt_rx_count           = rx_count_ff;
        nxt_tx_addr            = tx_addr_ff;
        nxt_tx_count           = tx_count_ff;
        nxt_div_hi             = div_hi_ff;
        nxt_rx_dma_enable      = rx_dma_enable_ff;
        nxt_tx_dma_enable      = tx_dma_enable_ff;
        nxt_rx_block_done_flag = rx_block_done_flag_ff;
        nxt_tx_block_done_flag = tx_block_done_flag_ff;
        nxt_error_irq_mask     = error_irq_mask_ff;
        nxt_rx_irq_mask        = rx_irq_mask_ff;
        nxt_tx_irq_mask        = tx_irq_mask_ff;
        if (wr_take) begin
            case (idx)
                `TID_IDX_VECTOR: begin
                    // only the base is stored; code and bit 0 are not writable
                    nxt_vec_base =
                        wdat[`TID_VEC_BASE_HI:`TID_VEC_BASE_LO];
                end
                `TID_IDX_RX_ADDR: begin
                    nxt_rx_addr = wdat;
                end
                `TID_IDX_RX_COUNT: begin
                    nxt_rx_count = wdat;
                end
                `TID_IDX_TX_ADDR: begin
                    nxt_tx_addr = wdat;
                end
                `TID_IDX_TX_COUNT: begin
                    nxt_tx_count = wdat;
                end
                `TID_IDX_CLK_EXT: begin
                    // reserved upper bits are dropped
                    nxt_div_hi =
                        wdat[`TID_DIV_HI_HI:`TID_DIV_HI_LO];
                end
                `TID_IDX_MASK: begin
                    nxt_rx_dma_enable  = wdat[`TID_MSK_RX_DMA];
                    nxt_tx_dma_enable  = wdat[`TID_MSK_TX_DMA];
                    nxt_error_irq_mask = wdat[`TID_MSK_ERR];
                    nxt_rx_irq_mask    = wdat[`TID_MSK_RX];
                    nxt_tx_irq_mask    = wdat[`TID_MSK_TX];
                    // flags: a zero clears, a one leaves them alone
                    if (!wdat[`TID_MSK_RX_DONE]) begin
                        nxt_rx_block_done_flag = 1'b0;
                    end
                    if (!wdat[`TID_MSK_TX_DONE]) begin
                        nxt_tx_block_done_flag = 1'b0;
                    end
                end
                default: begin
                    // unmapped index: write ignored
                end
            endcase
        end
        // block end: drop the enable, raise the flag; wins over software
        if (rx_dma_last) begin
            nxt_rx_dma_enable      = 1'b0;
            nxt_rx_block_done_flag = 1'b1;
        end
        if (tx_dma_last) begin
            nxt_tx_dma_enable      = 1'b0;
            nxt_tx_block_done_flag = 1'b1;
        end
    end

    // the code is frozen when the core takes the vector
    always_comb begin
        nxt_code = code_ff;
        if (irq_ack) begin
            nxt_code = live_code;
        end
    end

    // registers only; divider bits change on reset or a write and nothing else
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            vec_base_ff           <= 5'h00;
            rx_addr_ff            <= `TID_RST_BYTE;
            rx_count_ff           <= `TID_RST_BYTE;
            tx_addr_ff            <= `TID_RST_BYTE;
            tx_count_ff           <= `TID_RST_BYTE;
            div_hi_ff             <= `TID_RST_DIV_HI;
            rx_dma_enable_ff      <= 1'b0;
            tx_dma_enable_ff      <= 1'b0;
            rx_block_done_flag_ff <= 1'b0;
            tx_block_done_flag_ff <= 1'b0;
            error_irq_mask_ff     <= 1'b0;
            rx_irq_mask_ff        <= 1'b0;
            tx_irq_mask_ff        <= 1'b0;
            code_ff               <= tid_pkg::TID_SRC_NONE;
        end else begin
            vec_base_ff           <= nxt_vec_base;
            rx_addr_ff            <= nxt_rx_addr;
            rx_count_ff           <= nxt_rx_count;
            tx_addr_ff            <= nxt_tx_addr;
            tx_count_ff           <= nxt_tx_count;
            div_hi_ff             <= nxt_div_hi;
            rx_dma_enable_ff      <= nxt_rx_dma_enable;
            tx_dma_enable_ff      <= nxt_tx_dma_enable;
            rx_block_done_flag_ff <= nxt_rx_block_done_flag;
            tx_block_done_flag_ff <= nxt_tx_block_done_flag;
            error_irq_mask_ff     <= nxt_error_irq_mask;
            rx_irq_mask_ff        <= nxt_rx_irq_mask;
            tx_irq_mask_ff        <= nxt_tx_irq_mask;
            code_ff               <= nxt_code;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path and bus handshake

    logic [7:0] vec_byte;    // vector as read and as supplied
    logic [7:0] mask_byte;   // mask register as read

    // bit 0 is hard zero whatever was written
    assign vec_byte = {vec_base_ff, code_ff, 1'b0};
    // reserved bit 3 reads zero
    assign mask_byte = {rx_dma_enable_ff, tx_dma_enable_ff,
                        rx_block_done_flag_ff, tx_block_done_flag_ff,
                        1'b0, error_irq_mask_ff, rx_irq_mask_ff,
                        tx_irq_mask_ff};

    // read data captured on the first edge of the request
    always_comb begin
        nxt_rdata     = rdata_ff;
        nxt_bus_state = tid_pkg::TID_BUS_IDLE;
        if ((avs_read || avs_write)
            && (bus_state_ff == tid_pkg::TID_BUS_IDLE)) begin
            nxt_bus_state = tid_pkg::TID_BUS_ANSWER;
            nxt_rdata     = 32'h0000_0000;
            if (avs_read && aligned) begin
                case (idx)
                    `TID_IDX_VECTOR:   nxt_rdata[7:0] = vec_byte;
                    `TID_IDX_RX_ADDR:  nxt_rdata[7:0] = rx_addr_ff;
                    `TID_IDX_RX_COUNT: nxt_rdata[7:0] = rx_count_ff;
                    `TID_IDX_TX_ADDR:  nxt_rdata[7:0] = tx_addr_ff;
                    `TID_IDX_TX_COUNT: nxt_rdata[7:0] = tx_count_ff;
                    `TID_IDX_CLK_EXT:  nxt_rdata[1:0] = div_hi_ff;
                    `TID_IDX_MASK:     nxt_rdata[7:0] = mask_byte;
                    default:           nxt_rdata      = 32'h0000_0000;
                endcase
            end
        end
    end

    // registers only
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_state_ff <= tid_pkg::TID_BUS_IDLE;
            rdata_ff     <= 32'h0000_0000;
        end else begin
            bus_state_ff <= nxt_bus_state;
            rdata_ff     <= nxt_rdata;
        end
    end

    // wait in the first cycle, release in the answer cycle
    assign avs_waitrequest = (avs_read || avs_write)
                             && (bus_state_ff == tid_pkg::TID_BUS_IDLE);
    assign avs_readdata    = rdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // outputs to the dma and interrupt controllers

    // pointer fields; their meaning depends on the target select bit
    assign rx_dma_addr_ptr      = rx_addr_ff[`TID_PTR_HI:`TID_PTR_LO];
    assign rx_dma_ext_select    = rx_addr_ff[`TID_SEL_BIT];
    assign rx_dma_count_ptr     = rx_count_ff[`TID_PTR_HI:`TID_PTR_LO];
    assign rx_dma_target_select = rx_count_ff[`TID_SEL_BIT];
    assign tx_dma_addr_ptr      = tx_addr_ff[`TID_PTR_HI:`TID_PTR_LO];
    assign tx_dma_ext_select    = tx_addr_ff[`TID_SEL_BIT];
    assign tx_dma_count_ptr     = tx_count_ff[`TID_PTR_HI:`TID_PTR_LO];
    assign tx_dma_target_select = tx_count_ff[`TID_SEL_BIT];

    // vector seen by the core carries the frozen source code
    assign irq_vector_out = vec_byte;

    ////////////////////////////////////////////////////////////////////////
    // bus clock divider

    // nine-bit divisor: stored top bits over the low bits from outside
    assign bus_divider = {div_hi_ff, divider_low_bits};

    // runs only while the interface is on; the stored bits stay put
    tid_div u_div (
        .ref_clk       (ref_clk),
        .rst_b         (rst_b),
        .run           (interface_on),
        .fast          (fast_speed_select),
        .divider       (bus_divider),
        .bus_clk_level (bus_clk_level),
        .bus_clk_tick  (bus_clk_tick)
    );

endmodule : tid_top

`default_nettype wire

/* verification/tid_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// watches the top ports only; one clock, async low reset
module tid_asserts (
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       avs_read,
    input  wire logic       avs_write,
    input  wire logic       avs_waitrequest,
    input  wire logic       interface_on,
    input  wire logic [6:0] divider_low_bits,
    input  wire logic [8:0] bus_divider,
    input  wire logic       dma_hold_select,
    input  wire logic       error_pending,
    input  wire logic       rx_dma_req,
    input  wire logic       tx_dma_req,
    input  wire logic       rx_dma_last,
    input  wire logic       tx_dma_last,
    input  wire logic       irq_ack,
    input  wire logic       irq_req,
    input  wire logic [7:0] irq_vector_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // a fresh request, then exactly one wait state
    sequence s_req_start;
        $rose(avs_read || avs_write);
    endsequence
    sequence s_one_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    a_bus_one_wait: assert property (s_req_start |-> s_one_wait)
        else $error("bus answer not after one wait state");
    a_vec_lsb_zero: assert property (irq_vector_out[0] == 1'b0)
        else $error("vector bit 0 not zero");
    a_div_low_bits: assert property (bus_divider[6:0] == divider_low_bits)
        else $error("divider low bits differ");
    a_div_keep_off: assert property ($fell(interface_on) |=> $stable(bus_divider[8:7]))
        else $error("divider top bits lost on disable");
    // suspended mode: a pending error holds both channels
    a_rx_err_hold: assert property (!dma_hold_select && error_pending |-> !rx_dma_req)
        else $error("rx dma request during error");
    a_tx_err_hold: assert property (!dma_hold_select && error_pending |-> !tx_dma_req)
        else $error("tx dma request during error");
    a_rx_stop_end: assert property (rx_dma_last |-> ##1 !rx_dma_req)
        else $error("rx dma still enabled after block end");
    a_tx_stop_end: assert property (tx_dma_last |-> ##1 !tx_dma_req)
        else $error("tx dma still enabled after block end");
    a_ack_code_set: assert property (irq_ack && irq_req |=> irq_vector_out[2:1] != 2'b00)
        else $error("no source code after acknowledge");
endmodule : tid_asserts
bind tid_top tid_asserts u_chk (.*);
`default_nettype wire

/* verification/tid_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// core side: acknowledges interrupts, counts dma blocks down
module tid_core_model (
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       irq_req,
    input  wire logic [7:0] irq_vector_out,
    input  wire logic       rx_dma_req,
    input  wire logic       tx_dma_req,
    input  wire logic [3:0] ack_delay,
    input  wire logic [7:0] blk_len,
    output logic            irq_ack,
    output logic            rx_dma_last,
    output logic            tx_dma_last,
    output logic [7:0]      got_vec
);
    logic [3:0] wait_n;
    logic [7:0] rx_n;
    logic [7:0] tx_n;
    logic       took;  // vector is read one edge after the acknowledge
    // a slow ack_delay shows the latched code must hold
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            {irq_ack, rx_dma_last, tx_dma_last, took} <= 4'h0;
            {wait_n, rx_n, tx_n, got_vec} <= 28'h0;
        end else begin
            irq_ack <= irq_req && !irq_ack && wait_n == ack_delay;
            wait_n <= (irq_req && wait_n != ack_delay) ? wait_n + 4'h1 : 4'h0;
            took <= irq_ack;
            if (took) got_vec <= irq_vector_out;
            rx_dma_last <= rx_dma_req && !rx_dma_last && rx_n == 8'h01;
            rx_n <= !rx_dma_req ? blk_len : rx_n - {7'h0, !rx_dma_last};
            tx_dma_last <= tx_dma_req && !tx_dma_last && tx_n == 8'h01;
            tx_n <= !tx_dma_req ? blk_len : tx_n - {7'h0, !tx_dma_last};
        end
    end
endmodule : tid_core_model
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic ref_clk, rst_b, avs_read, avs_write, avs_waitrequest;
    logic interface_on, fast_speed_select, dma_hold_select, error_pending;
    logic rx_data_pending, tx_ready_pending, rx_dma_last, tx_dma_last;
    logic rx_dma_req, tx_dma_req, irq_ack, irq_req, bus_clk_level, bus_clk_tick;
    logic rx_dma_ext_select, rx_dma_target_select;
    logic tx_dma_ext_select, tx_dma_target_select;
    logic [6:0] divider_low_bits, rx_dma_addr_ptr, rx_dma_count_ptr;
    logic [6:0] tx_dma_addr_ptr, tx_dma_count_ptr;
    logic [9:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [7:0] irq_vector_out, got_vec, rd, blk_len;
    logic [8:0] bus_divider;
    logic [3:0] ack_delay;
    int n_errors = 0;
    int samples_checked = 0;
    int per;
    tid_top i_dut (.*, .avs_byteenable(4'hF));
    tid_core_model u_core (.*);
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // tests need about three thousand cycles, the divider periods most
    initial begin
        #40000;
        n_errors++;
        tally_and_finish;
    end
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // core cycles from one bus clock tick to the next
    task automatic tick_period(output int cyc);
        cyc = 0;
        do begin
            @(posedge ref_clk);
        end while (bus_clk_tick !== 1'b1);
        do begin
            @(posedge ref_clk);
            cyc++;
        end while (bus_clk_tick !== 1'b1);
    endtask : tick_period
    // one avalon access, held until waitrequest is sampled low at an edge
    task automatic acc(input logic we, input logic [7:0] idx,
                       input logic [7:0] wd);
        @(posedge ref_clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, wd};
        avs_write <= we;
        avs_read <= ~we;
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        // one idle edge so callers see the settled registers
        @(posedge ref_clk);
    endtask : acc
    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        acc(1'b0, idx, 8'h00);
        chk({2'b00, rd}, {2'b00, exp});
    endtask : rdc
    task tally_and_finish;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    initial begin
        {rst_b, avs_read, avs_write, fast_speed_select, error_pending} = 5'h0;
        {rx_data_pending, tx_ready_pending, interface_on} = 3'h1;
        {avs_address, avs_writedata, dma_hold_select} = 43'h1;
        {divider_low_bits, ack_delay, blk_len} = {7'h15, 4'h2, 8'h03};
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        // reset values; F8 is unmapped and reads zero
        for (int i = 8'hF8; i <= 8'hFF; i++) rdc(i[7:0], 8'h00);
        acc(1'b1, 8'hF9, 8'hFF);
        rdc(8'hF9, 8'hF8);
        acc(1'b1, 8'hFA, 8'hA5);
        acc(1'b1, 8'hFB, 8'h5A);
        acc(1'b1, 8'hFC, 8'h3C);
        acc(1'b1, 8'hFD, 8'hC3);
        chk({rx_dma_addr_ptr, rx_dma_ext_select}, 9'h0A5);
        chk({rx_dma_count_ptr, rx_dma_target_select}, 9'h05A);
        chk({tx_dma_addr_ptr, tx_dma_ext_select}, 9'h03C);
        chk({tx_dma_count_ptr, tx_dma_target_select}, 9'h0C3);
        acc(1'b1, 8'hFE, 8'h02);
        chk(bus_divider, 9'h115);
        interface_on <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk(bus_clk_level, 1'b1);
        rdc(8'hFE, 8'h02);
        interface_on <= 1'b1;
        acc(1'b1, 8'hFF, 8'h37);
        rdc(8'hFF, 8'h07);
        // both channels run one block with interrupts masked
        acc(1'b1, 8'hFF, 8'hC0);
        {rx_data_pending, tx_ready_pending} <= 2'b11;
        repeat (20) @(posedge ref_clk);
        rdc(8'hFF, 8'h30);
        chk(irq_req, 1'b0);
        acc(1'b1, 8'hFF, 8'h33);
        repeat (10) @(posedge ref_clk);
        chk(got_vec, 8'hFC);
        acc(1'b1, 8'hFF, 8'h01);
        repeat (10) @(posedge ref_clk);
        chk(got_vec, 8'hFE);
        // suspended mode with an error pending
        {dma_hold_select, error_pending} <= 2'b01;
        acc(1'b1, 8'hFF, 8'h84);
        repeat (10) @(posedge ref_clk);
        chk(rx_dma_req, 1'b0);
        chk(got_vec, 8'hFA);
        acc(1'b1, 8'hFF, 8'h80);
        chk(irq_req, 1'b0);
        error_pending <= 1'b0;
        repeat (10) @(posedge ref_clk);
        rdc(8'hFF, 8'h20);
        // bus clock period: 2 then 3 phases of divider plus two
        tick_period(per);
        chk(per[9:0], 10'h22E);
        fast_speed_select <= 1'b1;
        tick_period(per);
        chk(per[9:0], 10'h345);
        tally_and_finish;
    end
endmodule : tb_top
`default_nettype wire
